/* File: rtl/iscs_sequencer.sv */
// Sensor control sequencer: register upload, shutter and readout timing, converter path
`timescale 1ns/1ns
`include "iscs_defs.svh"

module iscs_sequencer (
   input wire logic clk,
   input wire logic rst,
   input wire logic port_select,
   input wire logic serial_port_select,
   input wire logic [15:0] par_word,
   input wire logic par_write,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load_en,
   input wire logic exp_start,
   input wire logic exp_end,
   input wire logic row_clock,
   input wire logic frame_start,
   input wire logic [9:0] conv_sample,
   input wire logic conv_sample_valid,
   output logic conv_sample_ready,
   input wire logic pixel_ready,
   output logic [9:0] converter_data_out,
   output logic converter_data_valid,
   output logic converter_drive_enable,
   output iscs_pkg::iscs_amp_type amp_ctrl,
   output logic [6:0] coarse_offset,
   output logic [6:0] fine_offset,
   output logic timeout,
   output logic pixel_valid,
   output logic last_line,
   output logic [10:0] row_pointer
);
   import iscs_pkg::*;

   // Upload port state
   iscs_cfg_type cfg_reg, cfg_next;
   iscs_amp_type amp_reg, amp_next;
   logic [15:0] shift_reg, shift_next;
   logic par_wr_d_reg, ser_clk_d_reg, ser_ld_d_reg;
   logic commit;
   iscs_upload_type word;

   // Apply a 12-bit upload to the register named by the index
   function automatic iscs_cfg_type write_cfg(input iscs_cfg_type c, input iscs_upload_type w);
      iscs_cfg_type r;
      r = c;
      unique case (w.idx)
         `ISCS_IDX_AMP: r.amp = w.data[6:0];
         `ISCS_IDX_COARSE: r.coarse = w.data[6:0];
         `ISCS_IDX_FINE: r.fine = w.data[6:0];
         `ISCS_IDX_CONV: r.conv = w.data[2:0];
         `ISCS_IDX_PIXELS: r.pixels = w.data;
         `ISCS_IDX_LINES: r.lines = w.data;
         `ISCS_IDX_INT_TIME: r.int_time = w.data;
         `ISCS_IDX_ROW_START: r.row_start = w.data[10:0];
         `ISCS_IDX_GRAN: r.gran = w.data[1:0];
         default: r = c;
      endcase
      return r;
   endfunction

   // Port choice, serial shifting and commit of a completed word
   always_comb begin
      shift_next = shift_reg;
      commit = 1'b0;
      word = iscs_upload_type'(par_word);
      if (port_select) begin
         commit = par_write && !par_wr_d_reg;
      end else if (serial_port_select) begin
         if (ser_clk && !ser_clk_d_reg) begin
            shift_next = {shift_reg[14:0], ser_data};
         end
         commit = ser_load_en && !ser_ld_d_reg;
         word = iscs_upload_type'(shift_reg);
      end
      cfg_next = commit ? write_cfg(cfg_reg, word) : cfg_reg;
      amp_next.gain = cfg_next.amp[`ISCS_AMP_GAIN_MSB:0];
      amp_next.unity_gain = cfg_next.amp[`ISCS_AMP_UNITY_BIT];
      amp_next.amp_standby = !cfg_next.amp[`ISCS_AMP_STANDBY_BIT];
      amp_next.path_first_active = cfg_next.amp[`ISCS_AMP_STANDBY_BIT];
      amp_next.path_second_active = cfg_next.amp[`ISCS_AMP_STANDBY_BIT]
         && cfg_next.amp[`ISCS_AMP_DUAL_BIT];
      amp_next.second_path_standby = !amp_next.path_second_active;
   end

   // Configuration and port registers, all zero after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_reg <= '0;
         amp_reg <= '0;
         shift_reg <= 16'h0000;
         par_wr_d_reg <= 1'b0;
         ser_clk_d_reg <= 1'b0;
         ser_ld_d_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         amp_reg <= amp_next;
         shift_reg <= shift_next;
         par_wr_d_reg <= par_write;
         ser_clk_d_reg <= ser_clk;
         ser_ld_d_reg <= ser_load_en;
      end
   end

   assign amp_ctrl = amp_reg;
   assign coarse_offset = cfg_reg.coarse;
   assign fine_offset = cfg_reg.fine;

   // Shutter sequencer state
   iscs_ss_state_type ss_reg, ss_next;
   logic [7:0] gran_cnt_reg, gran_cnt_next;
   logic [2:0] phase_reg, phase_next;
   logic [11:0] int_cnt_reg, int_cnt_next;
   logic timeout_reg, timeout_next;
   logic suspend, tick;
   logic [8:0] gran_period;

   assign suspend = exp_start || exp_end;
   assign gran_period = `ISCS_GRAN_BASE << cfg_reg.gran;
   assign tick = !suspend && ({1'b0, gran_cnt_reg} == gran_period - 9'h001);

   // Granulated clock, core reset, integration count and readable phase
   always_comb begin
      ss_next = ss_reg;
      phase_next = phase_reg;
      int_cnt_next = int_cnt_reg;
      timeout_next = timeout_reg;
      gran_cnt_next = gran_cnt_reg;
      if (!suspend) begin
         gran_cnt_next = tick ? 8'h00 : gran_cnt_reg + 8'h01;
      end
      if (tick) begin
         timeout_next = 1'b0;
      end
      unique case (ss_reg)
         SS_IDLE: begin
            if (exp_start) ss_next = SS_START;
         end
         SS_START: begin
            if (!exp_start) begin
               ss_next = SS_RESET;
               phase_next = 3'h0;
               int_cnt_next = 12'h000;
               gran_cnt_next = 8'h00;
            end
         end
         SS_RESET, SS_INTEG: begin
            if (exp_start) begin
               ss_next = SS_START;
            end else if (exp_end) begin
               ss_next = SS_END;
            end else if (tick) begin
               int_cnt_next = int_cnt_reg + 12'h001;
               if (int_cnt_next == cfg_reg.int_time) timeout_next = 1'b1;
               if (ss_reg == SS_RESET) begin
                  phase_next = phase_reg + 3'h1;
                  if (phase_next == `ISCS_RESET_PERIODS) ss_next = SS_INTEG;
               end
            end
         end
         SS_END: begin
            if (exp_start) begin
               ss_next = SS_START;
            end else if (!exp_end) begin
               ss_next = SS_READABLE;
               phase_next = 3'h0;
               gran_cnt_next = 8'h00;
            end
         end
         SS_READABLE: begin
            if (exp_start) begin
               ss_next = SS_START;
            end else if (tick) begin
               phase_next = phase_reg + 3'h1;
               if (phase_next == `ISCS_READABLE_PERIODS) ss_next = SS_IDLE;
            end
         end
         default: ss_next = SS_IDLE;
      endcase
   end

   // Shutter sequencer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ss_reg <= SS_IDLE;
         gran_cnt_reg <= 8'h00;
         phase_reg <= 3'h0;
         int_cnt_reg <= 12'h000;
         timeout_reg <= 1'b0;
      end else begin
         ss_reg <= ss_next;
         gran_cnt_reg <= gran_cnt_next;
         phase_reg <= phase_next;
         int_cnt_reg <= int_cnt_next;
         timeout_reg <= timeout_next;
      end
   end

   assign timeout = timeout_reg;

   // Readout sequencer state
   iscs_rd_state_type rd_reg, rd_next;
   logic [7:0] blank_reg, blank_next;
   logic [11:0] pix_reg, pix_next, line_reg, line_next;
   logic [10:0] row_reg, row_next;
   logic pv_reg, pv_next, last_reg, last_next;
   logic row_d_reg, frame_d_reg;

   // Row hold, blanking, pixel window, line count and row pointer
   always_comb begin
      rd_next = rd_reg;
      blank_next = blank_reg;
      pix_next = pix_reg;
      line_next = line_reg;
      row_next = row_reg;
      pv_next = pv_reg;
      last_next = last_reg;
      if (frame_start && !frame_d_reg) begin
         row_next = cfg_reg.row_start;
         line_next = `ISCS_LINE_INIT;
         last_next = 1'b0;
      end else if (!row_clock && row_d_reg) begin
         line_next = line_reg + 12'h001;
         if (line_reg != `ISCS_LINE_INIT) row_next = row_reg + 11'h001;
         last_next = (line_next == cfg_reg.lines);
      end
      if (row_clock) begin
         rd_next = RD_HOLD;
         pv_next = 1'b0;
      end else begin
         unique case (rd_reg)
            RD_IDLE: rd_next = RD_IDLE;
            RD_HOLD: begin
               rd_next = RD_BLANK;
               blank_next = 8'h00;
            end
            RD_BLANK: begin
               blank_next = blank_reg + 8'h01;
               if (blank_next == `ISCS_BLANK_CYC) begin
                  rd_next = RD_PIXELS;
                  pv_next = 1'b1;
                  pix_next = 12'h000;
               end
            end
            RD_PIXELS: begin
               if (pix_reg == cfg_reg.pixels) begin
                  rd_next = RD_IDLE;
                  pv_next = 1'b0;
               end else begin
                  pix_next = pix_reg + 12'h001;
               end
            end
            default: rd_next = RD_IDLE;
         endcase
      end
   end

   // Readout registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_reg <= RD_IDLE;
         blank_reg <= 8'h00;
         pix_reg <= 12'h000;
         line_reg <= `ISCS_LINE_INIT;
         row_reg <= 11'h000;
         pv_reg <= 1'b0;
         last_reg <= 1'b0;
         row_d_reg <= 1'b0;
         frame_d_reg <= 1'b0;
      end else begin
         rd_reg <= rd_next;
         blank_reg <= blank_next;
         pix_reg <= pix_next;
         line_reg <= line_next;
         row_reg <= row_next;
         pv_reg <= pv_next;
         last_reg <= last_next;
         row_d_reg <= row_clock;
         frame_d_reg <= frame_start;
      end
   end

   assign pixel_valid = pv_reg;
   assign last_line = last_reg;
   assign row_pointer = row_reg;

   // Converter transfer: companding below full linear, then polarity
   logic [9:0] curve, coded, above;
   logic [10:0] bent;
   logic drive_reg;
   always_comb begin
      above = conv_sample - `ISCS_KNEE;
      bent = {1'h0, `ISCS_KNEE_OUT} + {2'h0, above[9:1]} + {3'h0, above[9:2]};
      if (cfg_reg.conv[`ISCS_CONV_LINEAR_BIT]) begin
         curve = conv_sample;
      end else if (conv_sample < `ISCS_KNEE) begin
         curve = {conv_sample[8:0], 1'b0};
      end else begin
         curve = bent[10] ? '1 : bent[9:0]; // clip the bright end, no wrap to dark
      end
      coded = cfg_reg.conv[`ISCS_CONV_POLARITY_BIT] ? curve : ~curve;
   end

   // Output driver enable register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_reg <= 1'b0;
      end else begin
         drive_reg <= cfg_next.conv[`ISCS_CONV_DRIVE_BIT];
      end
   end

   assign converter_drive_enable = drive_reg;

   // Receiver stalls back up through the buffer to the sample source
   iscs_pair_buffer u_buf (
      .clk(clk),
      .rst(rst),
      .in_data(coded),
      .in_valid(conv_sample_valid),
      .in_ready(conv_sample_ready),
      .out_data(converter_data_out),
      .out_valid(converter_data_valid),
      .out_ready(pixel_ready)
   );

endmodule

/* File: rtl/iscs_defs.svh */
// Register indices, field positions and counts of the sensor control sequencer
`ifndef ISCS_DEFS_SVH
`define ISCS_DEFS_SVH

// Upload word layout
`define ISCS_IDX_MSB 15
`define ISCS_IDX_LSB 12
`define ISCS_DATA_MSB 11
`define ISCS_DATA_LSB 0

// Register indices of the 4-bit index field
`define ISCS_IDX_AMP 4'h0
`define ISCS_IDX_COARSE 4'h1
`define ISCS_IDX_FINE 4'h2
`define ISCS_IDX_CONV 4'h3
`define ISCS_IDX_PIXELS 4'h4
`define ISCS_IDX_LINES 4'h5
`define ISCS_IDX_INT_TIME 4'h6
`define ISCS_IDX_ROW_START 4'h7
`define ISCS_IDX_GRAN 4'h8

// Amplifier register fields
`define ISCS_AMP_GAIN_MSB 3
`define ISCS_AMP_UNITY_BIT 4
`define ISCS_AMP_DUAL_BIT 5
`define ISCS_AMP_STANDBY_BIT 6

// Converter register fields
`define ISCS_CONV_DRIVE_BIT 0
`define ISCS_CONV_LINEAR_BIT 1
`define ISCS_CONV_POLARITY_BIT 2

// Companding curve knee
`define ISCS_KNEE 10'h100
`define ISCS_KNEE_OUT 10'h200

// Shutter sequencer granularity: base period 32 clocks, shifted by 2-bit select
`define ISCS_GRAN_BASE 9'h020
`define ISCS_RESET_PERIODS 3'h4
`define ISCS_READABLE_PERIODS 3'h2

// Row blanking: 35 periods of the 4x column sequencer clock
`define ISCS_BLANK_CYC 8'h8c

// Line counter value that wraps to zero on the first row clock
`define ISCS_LINE_INIT 12'hfff

`endif

/* File: rtl/iscs_pkg.sv */
// Types shared by the sensor control sequencer
package iscs_pkg;

   typedef struct packed {
      logic [3:0] idx;
      logic [11:0] data;
   } iscs_upload_type;

   typedef struct packed {
      logic [6:0] amp;
      logic [6:0] coarse;
      logic [6:0] fine;
      logic [2:0] conv;
      logic [11:0] pixels;
      logic [11:0] lines;
      logic [11:0] int_time;
      logic [10:0] row_start;
      logic [1:0] gran;
   } iscs_cfg_type;

   typedef struct packed {
      logic path_first_active;
      logic path_second_active;
      logic second_path_standby;
      logic amp_standby;
      logic unity_gain;
      logic [3:0] gain;
   } iscs_amp_type;

   typedef enum logic [5:0] {
      SS_IDLE = 6'h01,
      SS_START = 6'h02,
      SS_RESET = 6'h04,
      SS_INTEG = 6'h08,
      SS_END = 6'h10,
      SS_READABLE = 6'h20
   } iscs_ss_state_type;

   typedef enum logic [3:0] {
      RD_IDLE = 4'h1,
      RD_HOLD = 4'h2,
      RD_BLANK = 4'h4,
      RD_PIXELS = 4'h8
   } iscs_rd_state_type;

endpackage

/* File: rtl/iscs_pair_buffer.sv */
// Two-entry buffer between the converter data path and the pixel receiver
`timescale 1ns/1ns
module iscs_pair_buffer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [9:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   import iscs_pkg::*;

   logic [9:0] head_reg, head_next, tail_reg, tail_next;
   logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
   logic ready_reg, ready_next;

   assign in_ready = ready_reg;
   assign out_data = head_reg;
   assign out_valid = head_v_reg;

   // Pop moves the tail forward, push fills the first free slot
   always_comb begin
      head_next = head_reg;
      tail_next = tail_reg;
      head_v_next = head_v_reg;
      tail_v_next = tail_v_reg;
      if (head_v_reg && out_ready) begin
         head_next = tail_reg;
         head_v_next = tail_v_reg;
         tail_v_next = 1'b0;
      end
      if (in_valid && !tail_v_reg) begin
         if (!head_v_next) begin
            head_next = in_data;
            head_v_next = 1'b1;
         end else begin
            tail_next = in_data;
            tail_v_next = 1'b1;
         end
      end
      // Ready is registered so the port comes straight from a flip-flop
      ready_next = !tail_v_next;
   end

   // Buffer storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         head_reg <= 10'h000;
         tail_reg <= 10'h000;
         head_v_reg <= 1'b0;
         tail_v_reg <= 1'b0;
         ready_reg <= 1'b1;
      end else begin
         head_reg <= head_next;
         tail_reg <= tail_next;
         head_v_reg <= head_v_next;
         tail_v_reg <= tail_v_next;
         ready_reg <= ready_next;
      end
   end

endmodule

/* File: tb/iscs_sequencer_checker.sv */
// Port checker for the sensor control sequencer
`timescale 1ns/1ns
module iscs_sequencer_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic par_write,
   input wire logic ser_load_en,
   input wire logic exp_start,
   input wire logic row_clock,
   input wire logic pixel_ready,
   input wire logic [9:0] converter_data_out,
   input wire logic converter_data_valid,
   input wire logic converter_drive_enable,
   input wire iscs_pkg::iscs_amp_type amp_ctrl,
   input wire logic [6:0] coarse_offset,
   input wire logic timeout,
   input wire logic pixel_valid,
   input wire logic last_line,
   input wire logic frame_start,
   input wire logic [10:0] row_pointer
);
   import iscs_pkg::*;
   logic [5:0] to_cnt_reg, to_cnt_next;
   logic [7:0] rc_cnt_reg, rc_cnt_next;
   logic [2:0] up_reg, up_next;
   // Timeout length, cycles since row clock low, recent upload strobes
   always_comb begin
      to_cnt_next = timeout ? to_cnt_reg + 6'h01 : 6'h00;
      rc_cnt_next = row_clock ? 8'h00 : rc_cnt_reg + 8'(rc_cnt_reg != 8'hff);
      up_next = {up_reg[1:0], par_write | ser_load_en};
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         to_cnt_reg <= 6'h00;
         rc_cnt_reg <= 8'h00;
         up_reg <= 3'h0;
      end else begin
         to_cnt_reg <= to_cnt_next;
         rc_cnt_reg <= rc_cnt_next;
         up_reg <= up_next;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rst_clear;
      $fell(rst) |-> coarse_offset == 7'h00 && !timeout && !last_line && row_pointer == 11'h000;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset left outputs set");
   property p_to_len;
      $fell(timeout) |-> to_cnt_reg == 6'h20;
   endproperty
   a_to_len: assert property (p_to_len) else $error("timeout width wrong");
   property p_start_hold;
      exp_start && !timeout |=> !timeout;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("sequencer ran during start");
   property p_row_drop;
      row_clock |-> ##2 !pixel_valid;
   endproperty
   a_row_drop: assert property (p_row_drop) else $error("pixel valid during row clock");
   property p_blank;
      $rose(pixel_valid) |-> rc_cnt_reg >= 8'h8a && rc_cnt_reg <= 8'h94;
   endproperty
   a_blank: assert property (p_blank) else $error("row blanking length wrong");
   property p_last_rise;
      $rose(last_line) |-> $past(row_clock, 2) || $past(row_clock, 3);
   endproperty
   a_last_rise: assert property (p_last_rise) else $error("last line rose off a row");
   property p_ptr_move;
      $changed(row_pointer) |-> $past(frame_start) || $past(frame_start, 2)
         || $past(row_clock, 2) || $past(row_clock, 3);
   endproperty
   a_ptr_move: assert property (p_ptr_move) else $error("row pointer moved alone");
   property p_coarse_up;
      $changed(coarse_offset) |-> up_reg != 3'h0;
   endproperty
   a_coarse_up: assert property (p_coarse_up) else $error("offset changed alone");
   property p_drive_up;
      $changed(converter_drive_enable) |-> up_reg != 3'h0;
   endproperty
   a_drive_up: assert property (p_drive_up) else $error("drive changed alone");
   property p_dual;
      !$past(rst) |-> amp_ctrl.second_path_standby == !amp_ctrl.path_second_active
         && amp_ctrl.path_first_active == !amp_ctrl.amp_standby
         && (amp_ctrl.path_first_active || !amp_ctrl.path_second_active);
   endproperty
   a_dual: assert property (p_dual) else $error("second path state wrong");
   property p_hold_out;
      converter_data_valid && !pixel_ready |=> converter_data_valid && $stable(converter_data_out);
   endproperty
   a_hold_out: assert property (p_hold_out) else $error("stalled word lost");
   c_timeout: cover property ($rose(timeout));
   c_pixels: cover property ($rose(pixel_valid));
   c_last: cover property ($rose(last_line));
endmodule
bind iscs_sequencer iscs_sequencer_checker iscs_sequencer_checker_inst (.*);

/* File: tb/iscs_ctrl_model.sv */
// Timing controller model driving the exposure and readout pulses
`timescale 1ns/1ns
module iscs_ctrl_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic timeout,
   input wire logic req_exp,
   input wire logic req_frame,
   input wire logic req_row,
   output logic exp_start,
   output logic exp_end,
   output logic frame_start,
   output logic row_clock
);
   logic to_seen_reg;
   // Pulses change on the falling clock edge only
   always_ff @(negedge clk or posedge rst) begin
      if (rst) begin
         exp_start <= 1'h0;
         exp_end <= 1'h0;
         frame_start <= 1'h0;
         row_clock <= 1'h0;
         to_seen_reg <= 1'h0;
      end else begin
         exp_start <= req_exp;
         frame_start <= req_frame;
         row_clock <= req_row;
         to_seen_reg <= timeout;
         exp_end <= to_seen_reg && !timeout;
      end
   end
endmodule

/* File: tb/iscs_sequencer_tb.sv */
// Self-checking bench for the sensor control sequencer
`timescale 1ns/1ns
module iscs_sequencer_tb;
   import iscs_pkg::*;
   typedef struct packed {
      logic ps, ss, ser;
      logic [15:0] word;
      logic [6:0] coarse, fine;
      logic act, drv;
   } iscs_row_type;
   logic clk = 1'h0, rst = 1'h1, port_select = 1'h1, serial_port_select = 1'h0;
   logic par_write = 1'h0, ser_clk = 1'h0, ser_data = 1'h0, ser_load_en = 1'h0;
   logic conv_sample_valid = 1'h0, pixel_ready = 1'h1;
   logic req_exp = 1'h0, req_frame = 1'h0, req_row = 1'h0;
   logic [15:0] par_word = 16'h0000;
   logic [9:0] conv_sample = 10'h000;
   logic exp_start, exp_end, row_clock, frame_start, conv_sample_ready;
   logic converter_data_valid, converter_drive_enable, timeout, pixel_valid, last_line;
   logic [9:0] converter_data_out;
   logic [6:0] coarse_offset, fine_offset;
   logic [10:0] row_pointer;
   iscs_amp_type amp_ctrl;
   int n_errors = 0, checked = 0, cycles = 0, acc;
   iscs_row_type r;
   iscs_row_type rows [11] = '{
      '{1'h1, 1'h0, 1'h0, 16'h107f, 7'h7f, 7'h00, 1'h0, 1'h0},
      '{1'h1, 1'h0, 1'h0, 16'h1000, 7'h00, 7'h00, 1'h0, 1'h0},
      '{1'h0, 1'h1, 1'h1, 16'h2040, 7'h00, 7'h40, 1'h0, 1'h0},
      '{1'h1, 1'h0, 1'h0, 16'h0060, 7'h00, 7'h40, 1'h1, 1'h0},
      '{1'h1, 1'h0, 1'h0, 16'h9123, 7'h00, 7'h40, 1'h1, 1'h0},
      '{1'h1, 1'h0, 1'h0, 16'h0040, 7'h00, 7'h40, 1'h0, 1'h0},
      '{1'h0, 1'h1, 1'h1, 16'h3001, 7'h00, 7'h40, 1'h0, 1'h1},
      '{1'h1, 1'h1, 1'h1, 16'h1055, 7'h00, 7'h40, 1'h0, 1'h1},
      '{1'h0, 1'h0, 1'h0, 16'h1011, 7'h00, 7'h40, 1'h0, 1'h1},
      '{1'h1, 1'h1, 1'h0, 16'h1022, 7'h22, 7'h40, 1'h0, 1'h1},
      '{1'h1, 1'h0, 1'h0, 16'h3000, 7'h22, 7'h40, 1'h0, 1'h0}};
   iscs_sequencer iscs_sequencer_inst (.clk, .rst, .port_select, .serial_port_select,
      .par_word, .par_write, .ser_clk, .ser_data, .ser_load_en, .exp_start, .exp_end,
      .row_clock, .frame_start, .conv_sample, .conv_sample_valid, .conv_sample_ready,
      .pixel_ready, .converter_data_out, .converter_data_valid, .converter_drive_enable,
      .amp_ctrl, .coarse_offset, .fine_offset, .timeout, .pixel_valid, .last_line,
      .row_pointer);
   iscs_ctrl_model iscs_ctrl_model_inst (.clk, .rst, .timeout, .req_exp, .req_frame,
      .req_row, .exp_start, .exp_end, .frame_start, .row_clock);
   // Master clock
   always #10 clk = ~clk;
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic par_up(input logic [15:0] w);
      par_word <= w;
      par_write <= 1'h1;
      tick(1);
      par_write <= 1'h0;
      tick(3);
   endtask
   // Serial word at 20 clocks per bit, first bit the top one
   task automatic ser_up(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         ser_data <= w[i];
         tick(10);
         ser_clk <= 1'h1;
         tick(10);
         ser_clk <= 1'h0;
      end
      ser_data <= ~w[0];
      ser_load_en <= 1'h1;
      tick(2);
      ser_load_en <= 1'h0;
      tick(3);
   endtask
   task automatic conv(input logic [15:0] cfg, input logic [9:0] x, input logic [9:0] e);
      par_up(cfg);
      conv_sample <= x;
      conv_sample_valid <= 1'h1;
      @(posedge clk);
      for (int k = 0; k < 8 && conv_sample_ready !== 1'h1; k++) @(posedge clk);
      conv_sample_valid <= 1'h0;
      for (int k = 0; k < 8 && converter_data_valid !== 1'h1; k++) @(posedge clk);
      check("coded", 16'(e), 16'(converter_data_out));
   endtask
   task automatic expo(input int hold);
      int n;
      n = 0;
      req_exp <= 1'h1;
      tick(hold);
      req_exp <= 1'h0;
      while (timeout !== 1'h1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      check("timeout delay", 16'h0001, 16'(n >= 318 && n <= 326));
      tick(40);
      $display("exposure hold %0d done", hold);
   endtask
   task automatic row(input logic last);
      int n;
      n = 0;
      req_row <= 1'h1;
      tick(1);
      req_row <= 1'h0;
      for (int k = 0; k < 300 && pixel_valid !== 1'h1; k++) @(posedge clk);
      while (pixel_valid === 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check("valid width", 16'h0005, 16'(n));
      check("last line", 16'(last), 16'(last_line));
      $display("row done");
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("Error watchdog expected end seen hang");
         test_done();
      end
   end
   initial begin
      tick(6);
      rst <= 1'h0;
      tick(2);
      check("reset coarse", 16'h0000, 16'(coarse_offset));
      check("reset standby", 16'h0001, 16'(amp_ctrl.amp_standby));
      for (int i = 0; i < 11; i++) begin
         r = rows[i];
         port_select <= r.ps;
         serial_port_select <= r.ss;
         tick(1);
         if (r.ser) ser_up(r.word); else par_up(r.word);
         check("coarse", 16'(r.coarse), 16'(coarse_offset));
         check("fine", 16'(r.fine), 16'(fine_offset));
         check("dual", 16'(r.act), 16'(amp_ctrl.path_second_active));
         check("standby", 16'(i < 3), 16'(amp_ctrl.amp_standby));
         check("drive", 16'(r.drv), 16'(converter_drive_enable));
         $display("row %0d done", i);
      end
      conv(16'h3003, 10'h155, 10'h2aa);
      conv(16'h3005, 10'h080, 10'h100);
      conv(16'h3005, 10'h300, 10'h380);
      conv(16'h3005, 10'h3ff, 10'h3ff);
      conv(16'h3007, 10'h155, 10'h155);
      // Fill the buffer against a stalled receiver, then drain it
      pixel_ready <= 1'h0;
      conv_sample <= 10'h011;
      conv_sample_valid <= 1'h1;
      acc = 0;
      repeat (6) begin
         @(posedge clk);
         if (conv_sample_ready === 1'h1) begin
            acc++;
            conv_sample <= conv_sample + 10'h001;
         end
      end
      conv_sample_valid <= 1'h0;
      pixel_ready <= 1'h1;
      check("fill", 16'h0002, 16'(acc));
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         check("drain", 16'(10'h011 + 10'(k)), 16'(converter_data_out));
      end
      $display("buffer done");
      par_up(16'h600a);
      // Doubled grain: no timeout where the base grain would give one
      par_up(16'h8001);
      req_exp <= 1'h1;
      tick(1);
      req_exp <= 1'h0;
      acc = 0;
      repeat (400) begin
         @(posedge clk);
         if (timeout !== 1'h0) acc++;
      end
      check("slow grain", 16'h0000, 16'(acc));
      par_up(16'h8000);
      $display("grain done");
      expo(1);
      expo(40);
      par_up(16'h4004);
      par_up(16'h5001);
      par_up(16'h7123);
      req_frame <= 1'h1;
      tick(3);
      req_frame <= 1'h0;
      tick(3);
      check("row start", 16'h0123, 16'(row_pointer));
      row(1'h0);
      row(1'h1);
      check("row next", 16'h0124, 16'(row_pointer));
      req_row <= 1'h1;
      tick(1);
      req_row <= 1'h0;
      for (int k = 0; k < 300 && pixel_valid !== 1'h1; k++) @(posedge clk);
      req_row <= 1'h1;
      tick(1);
      req_row <= 1'h0;
      tick(3);
      check("abort", 16'h0000, 16'(pixel_valid));
      rst <= 1'h1;
      tick(2);
      check("reset coarse", 16'h0000, 16'(coarse_offset));
      check("reset drive", 16'h0000, 16'(converter_drive_enable));
      check("reset row", 16'h0000, 16'(row_pointer));
      rst <= 1'h0;
      tick(2);
      $display("reset done");
      test_done();
   end
endmodule
